// [ciac_regs.vh]
/*
 * constants for the interrupt sequencing and addressing core:
 * vectors, register indices, addressing mode codes, flag positions.
 * assumes it is included once by name from the core module.
 */
`ifndef CIAC_REGS_VH
`define CIAC_REGS_VH

// ****************************************
// vector addresses, high byte first
// ****************************************
`define CIAC_VEC_RESTART 16'hFFFE
`define CIAC_VEC_NMI     16'hFFFC
`define CIAC_VEC_TRAP    16'hFFFA
`define CIAC_VEC_IRQ     16'hFFF8

// ****************************************
// register indices on the software port
// ****************************************
`define CIAC_IDX_PC      3'h0
`define CIAC_IDX_SP      3'h1
`define CIAC_IDX_X       3'h2
`define CIAC_IDX_A       3'h3
`define CIAC_IDX_B       3'h4
`define CIAC_IDX_CC      3'h5

// ****************************************
// flag positions and fixed bits
// ****************************************
`define CIAC_CC_C        0
`define CIAC_CC_V        1
`define CIAC_CC_Z        2
`define CIAC_CC_N        3
`define CIAC_CC_I        4
`define CIAC_CC_H        5
`define CIAC_CC_ONES     8'hC0
`define CIAC_CC_RESET    8'hD0

// ****************************************
// addressing modes
// ****************************************
`define CIAC_MODE_ACCA   3'h0
`define CIAC_MODE_ACCB   3'h1
`define CIAC_MODE_IMPL   3'h2
`define CIAC_MODE_IMM8   3'h3
`define CIAC_MODE_IMM16  3'h4
`define CIAC_MODE_DIR    3'h5
`define CIAC_MODE_EXT    3'h6
`define CIAC_MODE_IDX    3'h7

// ****************************************
// reset values and counts
// ****************************************
`define CIAC_PC_RESET    16'h0000
`define CIAC_SP_RESET    16'h0000
`define CIAC_X_RESET     16'h0000
`define CIAC_PUSH_LAST   3'h6
`define CIAC_BR_OFFSET   16'h0002

`endif

// [ciac_core.v]
/*
 * interrupt sequencing, programmer register set and operand address
 * generation of an 8-bit processor core.
 * assumes the instruction sequencer outside pulses the boundary, trap,
 * wait, branch, address and arithmetic strobes, and that external memory
 * answers a read strobe with data within the cycle of the strobe.
 */
// The implementer's own choices: the address-and-strobe port and the address map.
`include "ciac_regs.vh"

module ciac_core
(
    // clock, reset, enable
    input  wire        mclk_in,
    input  wire        reset_n_in,
    input  wire        clk_en_in,
    // request lines
    input  wire        irq_n_in,
    input  wire        nmi_n_in,
    input  wire        stop_req_n_in,
    // sequencer strobes
    input  wire        instr_done_in,
    input  wire        wait_for_event_instr_in,
    input  wire        software_trap_instr_in,
    input  wire        branch_in,
    input  wire        addr_calc_in,
    input  wire        alu_add_in,
    input  wire [2:0]  mode_in,
    input  wire [7:0]  byte2_in,
    input  wire [7:0]  byte3_in,
    // software register port
    input  wire [2:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // external memory
    output reg  [15:0] mem_addr_out,
    output reg  [7:0]  mem_wdata_out,
    output reg         mem_wr_out,
    output reg         mem_rd_out,
    input  wire [7:0]  mem_rdata_in,
    // status and address results
    output reg         busy_out,
    output reg         bus_free_out,
    output reg  [15:0] eff_addr_out,
    output reg  [15:0] operand_out
);

    // ****************************************
    // states
    // ****************************************
    localparam [5:0] ST_IDLE = 6'b00_0001;
    localparam [5:0] ST_PUSH = 6'b00_0010;
    localparam [5:0] ST_VHI  = 6'b00_0100;
    localparam [5:0] ST_VLO  = 6'b00_1000;
    localparam [5:0] ST_VEND = 6'b01_0000;
    localparam [5:0] ST_WAIT = 6'b10_0000;

    reg [5:0]  state_r;
    reg [15:0] pc_r;
    reg [15:0] sp_r;
    reg [15:0] x_r;
    reg [7:0]  acc_a_r;
    reg [7:0]  acc_b_r;
    reg [7:0]  cc_r;
    reg [15:0] ea_tmp_r;
    reg [15:0] vec_r;
    reg [7:0]  vec_hi_r;
    reg [2:0]  push_idx_r;
    reg        phase2_r;
    reg        irq_lvl_r;
    reg        nmi_prev_r;
    reg        nmi_pend_r;
    reg        bound_pend_r;
    reg        wait_mode_r;

    // ****************************************
    // byte chosen for each push step
    // ****************************************
    function [7:0] push_byte;
        input [2:0]  idx;
        input [15:0] pc;
        input [15:0] x;
        input [7:0]  a;
        input [7:0]  b;
        input [7:0]  cc;
        begin
            case (idx)
                3'h0:    push_byte = pc[7:0];
                3'h1:    push_byte = pc[15:8];
                3'h2:    push_byte = x[7:0];
                3'h3:    push_byte = x[15:8];
                3'h4:    push_byte = a;
                3'h5:    push_byte = b;
                default: push_byte = cc | `CIAC_CC_ONES;
            endcase
        end
    endfunction

    // ****************************************
    // request decode
    // ****************************************
    // only a change from high to low between two phase-two samples counts
    wire nmi_fall = nmi_prev_r & ~nmi_n_in;
    // stop-request low blocks both requests; trap and wait instructions are still taken
    wire irq_ok   = irq_lvl_r & ~cc_r[`CIAC_CC_I] & stop_req_n_in;
    wire nmi_ok   = nmi_pend_r & stop_req_n_in;
    // a trap instruction is itself the boundary event, so it skips the phase wait
    wire start_ok = bound_pend_r & ~phase2_r & (irq_ok | nmi_ok);
    wire [15:0] vec_sel = nmi_ok ? `CIAC_VEC_NMI : `CIAC_VEC_IRQ;
    wire idle = state_r[0];
    wire [15:0] pc_branch = pc_r + `CIAC_BR_OFFSET
                            + {{8{byte2_in[7]}}, byte2_in};

    // ****************************************
    // arithmetic flags for A plus operand
    // ****************************************
    wire [8:0] sum9 = {1'b0, acc_a_r} + {1'b0, byte2_in};
    wire [4:0] sum5 = {1'b0, acc_a_r[3:0]} + {1'b0, byte2_in[3:0]};
    wire       ovf  = (acc_a_r[7] == byte2_in[7]) & (sum9[7] != acc_a_r[7]);

    // ****************************************
    // request sampling
    // ****************************************
    always @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            phase2_r     <= 1'b0;
            irq_lvl_r    <= 1'b0;
            nmi_prev_r   <= 1'b1;
            nmi_pend_r   <= 1'b0;
            bound_pend_r <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // high marks phase two; the toggle stands in for the two-phase clock
            phase2_r <= ~phase2_r;
            if (phase2_r)
            begin
                // a level dropped before the boundary is simply never seen
                irq_lvl_r  <= ~irq_n_in;
                nmi_prev_r <= nmi_n_in;
            end
            // a new edge in the acceptance cycle wins over the clear
            if (phase2_r && nmi_fall)
                nmi_pend_r <= 1'b1;
            else if (start_ok && nmi_ok && idle)
                nmi_pend_r <= 1'b0;
            else if (state_r[5] && nmi_ok)
                nmi_pend_r <= 1'b0;
            if (instr_done_in)
                bound_pend_r <= 1'b1;
            else if (!phase2_r || !idle)
                bound_pend_r <= 1'b0;
        end
    end

    // ****************************************
    // sequencer and programmer registers
    // ****************************************
    always @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            // restart runs straight after release
            state_r       <= ST_VHI;
            vec_r         <= `CIAC_VEC_RESTART;
            pc_r          <= `CIAC_PC_RESET;
            sp_r          <= `CIAC_SP_RESET;
            x_r           <= `CIAC_X_RESET;
            acc_a_r       <= 8'h00;
            acc_b_r       <= 8'h00;
            cc_r          <= `CIAC_CC_RESET;
            ea_tmp_r      <= 16'h0000;
            vec_hi_r      <= 8'h00;
            push_idx_r    <= 3'h0;
            wait_mode_r   <= 1'b0;
            mem_addr_out  <= 16'h0000;
            mem_wdata_out <= 8'h00;
            mem_wr_out    <= 1'b0;
            mem_rd_out    <= 1'b0;
            busy_out      <= 1'b1;
            bus_free_out  <= 1'b0;
            eff_addr_out  <= 16'h0000;
            operand_out   <= 16'h0000;
            reg_rdata_out <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            // strobes are single-cycle pulses unless a state below raises them again
            mem_wr_out <= 1'b0;
            mem_rd_out <= 1'b0;

            // ****************************************
            // interrupt and restart sequence
            // ****************************************
            case (state_r)
                ST_IDLE:
                begin
                    if (software_trap_instr_in || wait_for_event_instr_in)
                    begin
                        state_r     <= ST_PUSH;
                        wait_mode_r <= wait_for_event_instr_in;
                        vec_r       <= `CIAC_VEC_TRAP;
                        push_idx_r  <= 3'h0;
                    end
                    else if (start_ok)
                    begin
                        state_r     <= ST_PUSH;
                        wait_mode_r <= 1'b0;
                        vec_r       <= vec_sel;
                        push_idx_r  <= 3'h0;
                    end
                end
                ST_PUSH:
                begin
                    mem_addr_out  <= sp_r;
                    mem_wdata_out <= push_byte(push_idx_r, pc_r, x_r,
                                               acc_a_r, acc_b_r, cc_r);
                    mem_wr_out    <= 1'b1;
                    sp_r          <= sp_r - 16'h0001;
                    push_idx_r    <= push_idx_r + 3'h1;
                    if (push_idx_r == `CIAC_PUSH_LAST)
                    begin
                        if (wait_mode_r)
                        begin
                            // bus-free waits for the wait state so it never overlaps a write
                            state_r          <= ST_WAIT;
                        end
                        else
                        begin
                            state_r          <= ST_VHI;
                            cc_r[`CIAC_CC_I] <= 1'b1;
                        end
                    end
                end
                ST_WAIT:
                begin
                    // leave only for an allowed request; the trap vector is replaced
                    if (irq_ok || nmi_ok)
                    begin
                        state_r      <= ST_VHI;
                        bus_free_out <= 1'b0;
                        vec_r        <= vec_sel;
                        cc_r[`CIAC_CC_I] <= 1'b1;
                    end
                    else
                    begin
                        // raised one cycle after the last push write
                        bus_free_out <= 1'b1;
                    end
                end
                ST_VHI:
                begin
                    mem_addr_out <= vec_r;
                    mem_rd_out   <= 1'b1;
                    state_r      <= ST_VLO;
                end
                ST_VLO:
                begin
                    // memory answers inside the strobe cycle, so this edge takes the high byte
                    vec_hi_r     <= mem_rdata_in;
                    mem_addr_out <= vec_r + 16'h0001;
                    mem_rd_out   <= 1'b1;
                    state_r      <= ST_VEND;
                end
                ST_VEND:
                begin
                    // both halves enter the counter together, never half a vector
                    pc_r     <= {vec_hi_r, mem_rdata_in};
                    state_r  <= ST_IDLE;
                    busy_out <= 1'b0;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
            // busy falls with the counter load, so software never sees half a vector
            if (!idle || start_ok || software_trap_instr_in || wait_for_event_instr_in)
                busy_out <= ~(state_r[4]);

            // ****************************************
            // operand addressing, only while idle
            // ****************************************
            if (idle && addr_calc_in)
            begin
                case (mode_in)
                    `CIAC_MODE_ACCA:  operand_out <= {8'h00, acc_a_r};
                    `CIAC_MODE_ACCB:  operand_out <= {8'h00, acc_b_r};
                    `CIAC_MODE_IMPL:  operand_out <= x_r;
                    `CIAC_MODE_IMM8:  operand_out <= {8'h00, byte2_in};
                    `CIAC_MODE_IMM16: operand_out <= {byte2_in, byte3_in};
                    `CIAC_MODE_DIR:   eff_addr_out <= {8'h00, byte2_in};
                    `CIAC_MODE_EXT:   eff_addr_out <= {byte2_in, byte3_in};
                    default:
                    begin
                        // the temporary keeps the sum; the index register is not written
                        ea_tmp_r     <= x_r + {8'h00, byte2_in};
                        eff_addr_out <= x_r + {8'h00, byte2_in};
                    end
                endcase
            end

            // ****************************************
            // relative branch and add with flags
            // ****************************************
            if (idle && branch_in)
                pc_r <= pc_branch;
            if (idle && alu_add_in)
            begin
                acc_a_r               <= sum9[7:0];
                cc_r[`CIAC_CC_C]      <= sum9[8];
                cc_r[`CIAC_CC_H]      <= sum5[4];
                cc_r[`CIAC_CC_N]      <= sum9[7];
                cc_r[`CIAC_CC_Z]      <= (sum9[7:0] == 8'h00);
                cc_r[`CIAC_CC_V]      <= ovf;
            end

            // ****************************************
            // software port: writes only land while idle
            // ****************************************
            if (reg_wr_in && idle)
            begin
                case (reg_addr_in)
                    `CIAC_IDX_PC: pc_r    <= reg_wdata_in;
                    `CIAC_IDX_SP: sp_r    <= reg_wdata_in;
                    `CIAC_IDX_X:  x_r     <= reg_wdata_in;
                    `CIAC_IDX_A:  acc_a_r <= reg_wdata_in[7:0];
                    `CIAC_IDX_B:  acc_b_r <= reg_wdata_in[7:0];
                    `CIAC_IDX_CC: cc_r    <= reg_wdata_in[7:0] | `CIAC_CC_ONES;
                    // unmapped indices are dropped; a hold here would undo a flag update
                    default:      ;
                endcase
            end
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    `CIAC_IDX_PC: reg_rdata_out <= pc_r;
                    `CIAC_IDX_SP: reg_rdata_out <= sp_r;
                    `CIAC_IDX_X:  reg_rdata_out <= x_r;
                    `CIAC_IDX_A:  reg_rdata_out <= {8'h00, acc_a_r};
                    `CIAC_IDX_B:  reg_rdata_out <= {8'h00, acc_b_r};
                    `CIAC_IDX_CC: reg_rdata_out <= {8'h00, cc_r | `CIAC_CC_ONES};
                    default:      reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// [ciac_mem_model.sv]
/*
 * behavioural memory on the far side of the core's memory port.
 * assumes one clock; read data answer within the cycle of the read strobe.
 */
module ciac_mem_model
(
    // clock
    input  wire logic        mclk_in,
    // memory port
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    input  wire logic        mem_wr_in,
    input  wire logic        mem_rd_in,
    output logic      [7:0]  mem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem_r [0:65535];

    // ****************************************
    // vectors, high byte at the even address
    // ****************************************
    initial
    begin
        mem_r[16'hFFF8] = 8'hDE;
        mem_r[16'hFFF9] = 8'hF0;
        mem_r[16'hFFFA] = 8'h9A;
        mem_r[16'hFFFB] = 8'hBC;
        mem_r[16'hFFFC] = 8'h56;
        mem_r[16'hFFFD] = 8'h78;
        mem_r[16'hFFFE] = 8'h12;
        mem_r[16'hFFFF] = 8'h34;
    end

    always @(posedge mclk_in)
    begin
        if (mem_wr_in)
            mem_r[mem_addr_in] <= mem_wdata_in;
    end

    // data stand while the strobe is high, as the core takes them at the next edge;
    // otherwise inverted so a sample outside the strobe cannot pass
    assign mem_rdata_out = mem_rd_in ? mem_r[mem_addr_in] : ~mem_r[mem_addr_in];
endmodule

// [ciac_core_asserts.sv]
/*
 * concurrent checks on the ports of the interrupt and addressing core.
 * assumes clock enable is held high, so every clock edge is an enabled one.
 */
module ciac_core_asserts
(
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        reset_n_in,
    // requests and strobes
    input wire logic        stop_req_n_in,
    input wire logic        wait_for_event_instr_in,
    input wire logic        software_trap_instr_in,
    input wire logic        addr_calc_in,
    input wire logic [2:0]  mode_in,
    input wire logic [7:0]  byte2_in,
    input wire logic [7:0]  byte3_in,
    // register port
    input wire logic [2:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // memory and status
    input wire logic [15:0] mem_addr_out,
    input wire logic        mem_wr_out,
    input wire logic        mem_rd_out,
    input wire logic        busy_out,
    input wire logic        bus_free_out,
    input wire logic [15:0] eff_addr_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    // ****************************************
    // sequences
    // ****************************************
    sequence s_push;
        mem_wr_out [*7];
    endsequence

    sequence s_vec(logic [15:0] v);
        mem_rd_out && mem_addr_out == v ##1 mem_rd_out && mem_addr_out == v + 16'h0001;
    endsequence

    // ****************************************
    // properties
    // ****************************************
    a_restart_fetch: assert property (
        !$past(reset_n_in) |-> ##1 s_vec(16'hFFFE) ##1 !busy_out)
        else $error("restart vector fetch wrong");
    a_push_decrement: assert property (
        $rose(mem_wr_out) |=>
        (mem_wr_out && mem_addr_out == $past(mem_addr_out) - 16'h0001) [*6] ##1 !mem_wr_out)
        else $error("stack push order wrong");
    a_trap_sequence: assert property (
        software_trap_instr_in |=> ##1 s_push ##1 s_vec(16'hFFFA) ##1 !busy_out)
        else $error("trap sequence wrong");
    a_wait_bus_free: assert property (
        wait_for_event_instr_in |=> ##1 s_push ##[1:2] bus_free_out)
        else $error("wait state not entered");
    a_wait_quiet: assert property (
        bus_free_out |-> !mem_wr_out)
        else $error("write while waiting");
    a_vector_pair: assert property (
        mem_rd_out && mem_addr_out[15:3] == 13'h1FFF && !mem_addr_out[0] |=>
        mem_rd_out && mem_addr_out == $past(mem_addr_out) + 16'h0001)
        else $error("vector low byte not fetched");
    a_push_vector: assert property (
        $fell(mem_wr_out) |-> ##[0:1]
        (bus_free_out || (mem_rd_out && mem_addr_out[15:3] == 13'h1FFF)))
        else $error("no vector after push");
    a_stop_blocks: assert property (
        !stop_req_n_in && !software_trap_instr_in && !wait_for_event_instr_in |=>
        !$rose(mem_wr_out))
        else $error("request served while stopped");
    a_cc_ones: assert property (
        reg_rd_in && reg_addr_in == 3'h5 |=>
        reg_rdata_out[15:8] == 8'h00 && reg_rdata_out[7:6] == 2'b11)
        else $error("flag register fixed bits wrong");
    a_unmapped_zero: assert property (
        reg_rd_in && reg_addr_in[2:1] == 2'b11 |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_direct_addr: assert property (
        addr_calc_in && mode_in == 3'h5 |=> eff_addr_out == {8'h00, $past(byte2_in)})
        else $error("direct address wrong");
    a_extended_addr: assert property (
        addr_calc_in && mode_in == 3'h6 |=>
        eff_addr_out == {$past(byte2_in), $past(byte3_in)})
        else $error("extended address wrong");
endmodule

bind ciac_core ciac_core_asserts i_ciac_core_asserts (.mclk_in, .reset_n_in,
    .stop_req_n_in, .wait_for_event_instr_in, .software_trap_instr_in, .addr_calc_in,
    .mode_in, .byte2_in, .byte3_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out,
    .mem_addr_out, .mem_wr_out, .mem_rd_out, .busy_out, .bus_free_out, .eff_addr_out);

// [ciac_core_tb.sv]
/*
 * self-checking bench for the interrupt and addressing core with a memory model.
 * assumes the memory model's vectors; clock enable is held high throughout.
 */
module ciac_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        irq_n_in = 1'b1;
    logic        nmi_n_in = 1'b1;
    logic        stop_req_n_in = 1'b1;
    logic [5:0]  stb = 6'h00;
    logic [2:0]  mode_in = 3'h0;
    logic [7:0]  byte2_in = 8'h00;
    logic [7:0]  byte3_in = 8'h00;
    logic [2:0]  reg_addr_in = 3'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [15:0] reg_rdata_out, mem_addr_out, eff_addr_out, operand_out;
    logic [7:0]  mem_wdata_out, mem_rdata_in;
    logic        mem_wr_out, mem_rd_out, busy_out, bus_free_out;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [15:0] mode_exp [8] = '{16'h007F, 16'h0022, 16'hFFF0, 16'h00F0,
                                  16'hF05A, 16'h00F0, 16'hF05A, 16'h00E0};
    logic [7:0]  stk_exp [7] = '{8'h68, 8'h24, 8'hF0, 8'hFF, 8'h80, 8'h22, 8'hEA};

    ciac_core i_ciac_core (.mclk_in, .reset_n_in, .clk_en_in(1'b1), .irq_n_in, .nmi_n_in,
        .stop_req_n_in, .instr_done_in(stb[0]), .wait_for_event_instr_in(stb[1]),
        .software_trap_instr_in(stb[2]), .branch_in(stb[3]), .addr_calc_in(stb[4]),
        .alu_add_in(stb[5]), .mode_in, .byte2_in, .byte3_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_addr_out, .mem_wdata_out, .mem_wr_out,
        .mem_rd_out, .mem_rdata_in, .busy_out, .bus_free_out, .eff_addr_out, .operand_out);

    ciac_mem_model i_ciac_mem_model (.mclk_in, .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out), .mem_wr_in(mem_wr_out), .mem_rd_in(mem_rd_out),
        .mem_rdata_out(mem_rdata_in));

    always #2.5 mclk_in = ~mclk_in;

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
    endtask

    task automatic pulse(input logic [5:0] s);
        @(posedge mclk_in);
        stb <= s;
        @(posedge mclk_in);
        stb <= 6'h00;
        #1;
    endtask

    // bounded, so a stuck sequence shows as a mismatch instead of a hang
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge mclk_in);
        #1;
        while (busy_out !== 1'b0 && n < 60)
        begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk({15'h0000, busy_out}, 16'h0000);
    endtask

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask

    task automatic complete_run;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (20) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        wait_idle();
        rd_chk(3'h0, 16'h1234);
        rd_chk(3'h5, 16'h00D0);
        for (int r = 1; r < 5; r++)
            rd_chk(r[2:0], 16'h0000);
        tend("restart");
        wr(3'h1, 16'h01FF);
        wr(3'h2, 16'hFFF0);
        wr(3'h3, 16'h007F);
        wr(3'h4, 16'h0022);
        wr(3'h5, 16'h0000);
        rd_chk(3'h5, 16'h00C0);
        rd_chk(3'h6, 16'h0000);
        rd_chk(3'h4, 16'h0022);
        tend("registers");
        byte2_in <= 8'hF0;
        byte3_in <= 8'h5A;
        for (int m = 0; m < 8; m++)
        begin
            mode_in <= m[2:0];
            pulse(6'h10);
            chk(m < 5 ? operand_out : eff_addr_out, mode_exp[m]);
        end
        rd_chk(3'h2, 16'hFFF0);
        tend("modes");
        wr(3'h0, 16'h1000);
        byte2_in <= 8'h80;
        pulse(6'h08);
        rd_chk(3'h0, 16'h0F82);
        byte2_in <= 8'h7F;
        pulse(6'h08);
        rd_chk(3'h0, 16'h1003);
        byte2_in <= 8'h01;
        pulse(6'h20);
        rd_chk(3'h3, 16'h0080);
        rd_chk(3'h5, 16'h00EA);
        tend("branch and add");
        wr(3'h0, 16'h2468);
        pulse(6'h04);
        wait_idle();
        for (int k = 0; k < 7; k++)
            chk({8'h00, i_ciac_mem_model.mem_r[16'h01FF - k[15:0]]}, {8'h00, stk_exp[k]});
        rd_chk(3'h0, 16'h9ABC);
        rd_chk(3'h5, 16'h00FA);
        rd_chk(3'h1, 16'h01F8);
        tend("trap");
        irq_n_in <= 1'b0;
        pulse(6'h01);
        repeat (10) @(posedge mclk_in);
        rd_chk(3'h0, 16'h9ABC);
        stop_req_n_in <= 1'b0;
        wr(3'h5, 16'h0000);
        pulse(6'h01);
        repeat (10) @(posedge mclk_in);
        rd_chk(3'h0, 16'h9ABC);
        stop_req_n_in <= 1'b1;
        pulse(6'h01);
        wait_idle();
        rd_chk(3'h0, 16'hDEF0);
        rd_chk(3'h5, 16'h00D0);
        chk({8'h00, i_ciac_mem_model.mem_r[16'h01F8]}, 16'h00BC);
        chk({8'h00, i_ciac_mem_model.mem_r[16'h01F2]}, 16'h00C0);
        irq_n_in <= 1'b1;
        tend("maskable");
        wr(3'h5, 16'h0000);
        irq_n_in <= 1'b0;
        nmi_n_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        nmi_n_in <= 1'b1;
        pulse(6'h01);
        wait_idle();
        rd_chk(3'h0, 16'h5678);
        irq_n_in <= 1'b1;
        tend("both requests");
        pulse(6'h02);
        repeat (10) @(posedge mclk_in);
        #1 chk({15'h0000, bus_free_out}, 16'h0001);
        irq_n_in <= 1'b0;
        repeat (20) @(posedge mclk_in);
        #1 chk({15'h0000, bus_free_out}, 16'h0001);
        nmi_n_in <= 1'b0;
        wait_idle();
        rd_chk(3'h0, 16'h5678);
        chk({15'h0000, bus_free_out}, 16'h0000);
        nmi_n_in <= 1'b1;
        irq_n_in <= 1'b1;
        tend("wait");
        complete_run();
    end
endmodule
